// [common/exc_defines.vh]
// exception unit constants: numbers, vectors, priorities, states
// assumes 32-bit byte addressing and 4-byte vector entries
`ifndef EXC_DEFINES_VH
`define EXC_DEFINES_VH
// ****************************************************************
// exception numbers
// ****************************************************************
`define EXC_NUM_RESET     6'h01
`define EXC_NUM_NMI       6'h02
`define EXC_NUM_HARD      6'h03
`define EXC_NUM_MEM       6'h04
`define EXC_NUM_BUS       6'h05
`define EXC_NUM_USAGE     6'h06
`define EXC_NUM_SVC       6'h0B
`define EXC_NUM_PENDSRV   6'h0E
`define EXC_NUM_TICK      6'h0F
`define EXC_NUM_IRQ0      6'h10
`define EXC_NUM_LAST      6'h32
`define EXC_COUNT         51
`define IRQ_COUNT         35
// ****************************************************************
// vector table
// ****************************************************************
`define VEC_OFF_SP        32'h0000_0000
`define VEC_OFF_RESET     32'h0000_0004
`define VEC_OFF_SVC       32'h0000_002C
`define VEC_OFF_PENDSRV   32'h0000_0038
`define VEC_OFF_TICK      32'h0000_003C
`define VEC_OFF_IRQ0      32'h0000_0040
`define VEC_STEP          32'h0000_0004
`define VEC_BASE_RESET    32'h0000_0000
`define VEC_BASE_MASK     32'hFFFF_FF80
// ****************************************************************
// priorities, biased by +3 so reset -3 is 0
// ****************************************************************
`define PRI_RESET         5'h00
`define PRI_NMI           5'h01
`define PRI_HARD          5'h02
`define PRI_BIAS          5'h03
`define PRI_THREAD        5'h1F
`define PRI_CFG_RESET     4'h0
// ****************************************************************
// sequencer states, one-hot
// ****************************************************************
`define ST_FETCH_SP       4'h1
`define ST_FETCH_PC       4'h2
`define ST_RUN            4'h4
`define ST_FETCH_VEC      4'h8
`endif

// [verilog/exception_unit.v]
// exception unit: per-source state, priority pick, vector fetch
// assumes pipeline and vector memory run on SYS_CLK_IN; irq and nmi
// lines are pins and are synchronised here
//
// Overview of operation
// RQ1 - each source is inactive when neither its active nor pending bit is set
// RQ2 - peripheral or software request sets the source pending
// RQ3 - nested handlers keep all interrupted exceptions marked active
// RQ4 - a new request while active gives active-and-pending
// RQ5 - reset halts core; afterwards fetch reset vector, run privileged thread
// RQ6 - nmi always enabled, fixed priority -2, never masked
// RQ7 - only reset preempts a running nmi handler
// RQ8 - hard fault, priority -1, on entry error or unmanageable fault
// RQ9 - memory fault on protection violation; execute-never fetch always aborts
// RQ10 - bus fault on memory errors; precise synchronous, imprecise asynchronous
// RQ11 - usage fault on undefined, unaligned, bad state, bad return
// RQ12 - optional usage fault for unaligned word/halfword and divide by zero
// RQ13 - supervisor call is exception 11, configurable, vector 0x2C, synchronous
// RQ14 - pended system service is exception 14, asynchronous, vector 0x38
// RQ15 - system tick is exception 15 from timer zero or software, vector 0x3C
// RQ16 - irq n is exception 16+n, vector 0x40 plus 4 per irq
// RQ17 - asynchronous exceptions may let one more instruction complete first
// RQ18 - configurable sources can be disabled; reset, nmi, hard fault cannot
// RQ19 - irq lines 0 to 34 each have their own service routine
// RQ20 - vector table supplies initial stack pointer and every handler address
// RQ21 - software sets bit 0 of every vector entry
// RQ22 - status field gives exception number; irq number is that minus 16
// RQ23 - lower value wins; equal priority goes to lowest exception number
// RQ24 - configurable priorities 0 to 15, default 0, below fixed ones
// RQ25 - vector table sits at zero after reset, relocatable later
// RQ26 - exception numbers 7-10 and 12-13 are reserved, never activated
`timescale 1ns/100ps
`include "exc_defines.vh"
module exception_unit (
  input  wire         SYS_CLK_IN,
  input  wire         RESET_N_IN,
  input  wire [34:0]  IRQ_IN,
  input  wire         NMI_IN,
  input  wire [34:0]  IRQ_SW_SET_IN,
  input  wire         NMI_SW_SET_IN,
  input  wire         PENDSRV_SET_IN,
  input  wire         TICK_ZERO_IN,
  input  wire         TICK_SW_SET_IN,
  input  wire         SVC_EXEC_IN,
  input  wire         PROT_VIOL_IN,
  input  wire         FIXED_PROT_VIOL_IN,
  input  wire         XN_FETCH_IN,
  input  wire         MEMORY_PROTECTION_UNIT_EN_IN,
  input  wire         BUS_ERR_PRECISE_IN,
  input  wire         BUS_ERR_IMPRECISE_IN,
  input  wire         UNDEF_INSTR_IN,
  input  wire         ILLEGAL_UNALIGNED_IN,
  input  wire         INVALID_STATE_IN,
  input  wire         RETURN_ERR_IN,
  input  wire         UNALIGNED_ACCESS_IN,
  input  wire         DIV_ZERO_IN,
  input  wire         TRAP_UNALIGNED_EN_IN,
  input  wire         TRAP_DIV_ZERO_EN_IN,
  input  wire [50:0]  ENABLE_IN,
  input  wire [203:0] PRIORITY_IN,
  input  wire         VTOR_WE_IN,
  input  wire [31:0]  VTOR_IN,
  input  wire         ENTRY_OK_IN,
  input  wire         RETURN_IN,
  input  wire [5:0]   RETURN_EXC_IN,
  input  wire [5:0]   RESUME_EXC_IN,
  input  wire         VEC_RD_VALID_IN,
  input  wire         VEC_RD_ERR_IN,
  input  wire [31:0]  VEC_RD_DATA_IN,
  output reg          VEC_RD_REQ_OUT,
  output reg  [31:0]  VEC_ADDR_OUT,
  output reg          CORE_RUN_OUT,
  output reg          PRIV_THREAD_OUT,
  output reg          SP_LOAD_OUT,
  output reg          PC_LOAD_OUT,
  output reg  [31:0]  LOAD_DATA_OUT,
  output reg          ENTRY_OUT,
  output reg          ENTRY_ASYNC_OUT,
  output reg  [8:0]   INTERRUPT_STATUS_FIELD_OUT,
  output reg  [8:0]   IRQ_NUMBER_OUT,
  output reg  [50:0]  PENDING_OUT,
  output reg  [50:0]  ACTIVE_OUT
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [4:0] prio_of;
    input [5:0]   n;
    input [203:0] p;
    begin
      case (n)
        `EXC_NUM_RESET: prio_of = `PRI_RESET;
        `EXC_NUM_NMI:   prio_of = `PRI_NMI;   // [RQ6]
        `EXC_NUM_HARD:  prio_of = `PRI_HARD;  // [RQ8]
        default:        prio_of = {1'b0, p[n*4 +: 4]} + `PRI_BIAS; // [RQ24]
      endcase
    end
  endfunction

  function usable;
    input [5:0] n;
    begin
      // reserved numbers never take a handler [RQ26]
      usable = (n >= `EXC_NUM_NMI) && (n <= `EXC_NUM_LAST) &&
               !((n >= 6'h07) && (n <= 6'h0A)) &&
               !((n == 6'h0C) || (n == 6'h0D));
    end
  endfunction

  function enabled;
    input [5:0]  n;
    input [50:0] en;
    begin
      // fixed-priority sources ignore the enable bits [RQ18]
      if ((n == `EXC_NUM_NMI) || (n == `EXC_NUM_HARD))
        enabled = 1'b1;
      else
        enabled = en[n];
    end
  endfunction

  function is_async;
    input [5:0] n;
    input       imprecise;
    begin
      case (n)
        `EXC_NUM_NMI, `EXC_NUM_PENDSRV, `EXC_NUM_TICK: is_async = 1'b1;
        `EXC_NUM_BUS: is_async = imprecise; // [RQ10]
        default:      is_async = (n >= `EXC_NUM_IRQ0); // [RQ14] [RQ16]
      endcase
    end
  endfunction

  // ****************************************************************
  // pin synchronisers: a change counts once ff2 and ff3 agree
  // ****************************************************************
  reg [35:0] sync1_reg;
  reg [35:0] sync2_reg;
  reg [35:0] sync3_reg;
  reg [35:0] line_reg;
  reg [35:0] line_next;
  integer    k;

  always @* begin
    line_next = line_reg;
    for (k = 0; k < 36; k = k + 1) begin
      if (sync2_reg[k] == sync3_reg[k])
        line_next[k] = sync3_reg[k];
    end
  end

  always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sync1_reg <= 36'h0_0000_0000;
      sync2_reg <= 36'h0_0000_0000;
      sync3_reg <= 36'h0_0000_0000;
      line_reg  <= 36'h0_0000_0000;
    end else begin
      sync1_reg <= {NMI_IN, IRQ_IN};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      line_reg  <= line_next;
    end
  end

  // rising edges only, so a held line does not re-pend after entry
  wire [35:0] line_rise = line_next & ~line_reg;

  // ****************************************************************
  // state and priority pick
  // ****************************************************************
  reg  [3:0]  state_reg;
  reg  [50:0] pend_reg;
  reg  [50:0] act_reg;
  reg  [31:0] vbase_reg;
  reg  [5:0]  ent_num_reg;
  reg  [5:0]  interrupt_status_field_reg;
  reg         imprecise_reg;

  reg  [5:0]  best_num;
  reg  [4:0]  best_pri;
  reg         best_ok;
  reg  [4:0]  cur_pri;
  reg  [4:0]  pri_k;
  reg  [5:0]  num_k;
  integer     i;

  always @* begin
    best_num = 6'h00;
    best_pri = `PRI_THREAD;
    best_ok  = 1'b0;
    cur_pri  = `PRI_THREAD;
    pri_k    = `PRI_THREAD;
    num_k    = 6'h00;
    for (i = 2; i < `EXC_COUNT; i = i + 1) begin
      num_k = i[5:0];
      pri_k = prio_of(num_k, PRIORITY_IN);
      // execution priority is the best of all active handlers [RQ3]
      if (act_reg[i] && (pri_k < cur_pri))
        cur_pri = pri_k;
      // strict compare in ascending order keeps the lowest number [RQ23]
      if (pend_reg[i] && usable(num_k) && enabled(num_k, ENABLE_IN) &&
          (!best_ok || (pri_k < best_pri))) begin
        best_ok  = 1'b1;
        best_pri = pri_k;
        best_num = num_k;
      end
    end
  end

  // a running nmi holds cur_pri at -2, so nothing but reset wins [RQ7]
  wire take = best_ok && (best_pri < cur_pri) && ENTRY_OK_IN;

  // ****************************************************************
  // fault sources and escalation
  // ****************************************************************
  wire mem_ev   = (PROT_VIOL_IN & MEMORY_PROTECTION_UNIT_EN_IN) |
                  FIXED_PROT_VIOL_IN | XN_FETCH_IN; // [RQ9]
  wire usage_ev = UNDEF_INSTR_IN | ILLEGAL_UNALIGNED_IN |
                  INVALID_STATE_IN | RETURN_ERR_IN | // [RQ11]
                  (UNALIGNED_ACCESS_IN & TRAP_UNALIGNED_EN_IN) |
                  (DIV_ZERO_IN & TRAP_DIV_ZERO_EN_IN); // [RQ12]

  // a synchronous fault that cannot be taken now escalates, except the bad_state usage fault
  wire mem_esc   = !ENABLE_IN[4] ||
                   (prio_of(`EXC_NUM_MEM, PRIORITY_IN) >= cur_pri);
  wire bus_esc   = !ENABLE_IN[5] ||
                   (prio_of(`EXC_NUM_BUS, PRIORITY_IN) >= cur_pri);
  wire usage_esc = !ENABLE_IN[6] ||
                   (prio_of(`EXC_NUM_USAGE, PRIORITY_IN) >= cur_pri);
  wire svc_esc   = !ENABLE_IN[11] ||
                   (prio_of(`EXC_NUM_SVC, PRIORITY_IN) >= cur_pri);

  wire vec_done  = state_reg[3] && VEC_RD_VALID_IN;
  wire vec_err   = vec_done && VEC_RD_ERR_IN;
  wire vec_good  = vec_done && !VEC_RD_ERR_IN;
  // handler address with bit 0 clear would run in the wrong state
  wire bad_state = vec_good && !VEC_RD_DATA_IN[0]; // [RQ21]

  reg [50:0] set_ev;
  always @* begin
    set_ev = 51'h0;
    set_ev[50:16] = line_rise[34:0] | IRQ_SW_SET_IN; // [RQ2] [RQ19]
    set_ev[2]  = line_rise[35] | NMI_SW_SET_IN; // [RQ6]
    set_ev[3]  = vec_err | (mem_ev & mem_esc) | // [RQ8]
                 (BUS_ERR_PRECISE_IN & bus_esc) |
                 (usage_ev & usage_esc) | (SVC_EXEC_IN & svc_esc);
    set_ev[4]  = mem_ev & !mem_esc;
    set_ev[5]  = (BUS_ERR_PRECISE_IN & !bus_esc) |
                 BUS_ERR_IMPRECISE_IN; // [RQ10]
    set_ev[6]  = (usage_ev & !usage_esc) | bad_state;
    set_ev[11] = SVC_EXEC_IN & !svc_esc; // [RQ13]
    set_ev[14] = PENDSRV_SET_IN; // [RQ14]
    set_ev[15] = TICK_ZERO_IN | TICK_SW_SET_IN; // [RQ15]
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  reg [50:0] clr_pend;
  reg [50:0] set_act;
  reg [50:0] clr_act;

  always @* begin
    clr_pend = 51'h0;
    set_act  = 51'h0;
    clr_act  = 51'h0;
    if (vec_good) begin
      clr_pend[ent_num_reg] = 1'b1;
      set_act[ent_num_reg]  = 1'b1;
    end
    if (RETURN_IN && state_reg[2])
      clr_act[RETURN_EXC_IN] = 1'b1;
  end

  always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      // core halted while reset is low [RQ5]
      state_reg       <= `ST_FETCH_SP;
      pend_reg        <= 51'h0;
      act_reg         <= 51'h0;
      vbase_reg       <= `VEC_BASE_RESET; // [RQ25]
      ent_num_reg     <= 6'h00;
      interrupt_status_field_reg        <= 6'h00;
      imprecise_reg   <= 1'b0;
      VEC_RD_REQ_OUT  <= 1'b0;
      VEC_ADDR_OUT    <= 32'h0000_0000;
      CORE_RUN_OUT    <= 1'b0;
      PRIV_THREAD_OUT <= 1'b0;
      SP_LOAD_OUT     <= 1'b0;
      PC_LOAD_OUT     <= 1'b0;
      LOAD_DATA_OUT   <= 32'h0000_0000;
      ENTRY_OUT       <= 1'b0;
      ENTRY_ASYNC_OUT <= 1'b0;
    end else begin
      SP_LOAD_OUT <= 1'b0;
      PC_LOAD_OUT <= 1'b0;
      ENTRY_OUT   <= 1'b0;
      // set wins over clear; active keeps pending free to set [RQ1] [RQ4]
      pend_reg <= (pend_reg & ~clr_pend) | set_ev;
      act_reg  <= (act_reg & ~clr_act) | set_act;
      if (BUS_ERR_IMPRECISE_IN)
        imprecise_reg <= 1'b1;
      else if (BUS_ERR_PRECISE_IN)
        imprecise_reg <= 1'b0;
      case (state_reg)
        `ST_FETCH_SP: begin
          VEC_RD_REQ_OUT <= 1'b1;
          VEC_ADDR_OUT   <= vbase_reg + `VEC_OFF_SP; // [RQ20]
          if (VEC_RD_REQ_OUT && VEC_RD_VALID_IN) begin
            SP_LOAD_OUT   <= 1'b1;
            LOAD_DATA_OUT <= VEC_RD_DATA_IN;
            VEC_ADDR_OUT  <= vbase_reg + `VEC_OFF_RESET;
            state_reg     <= `ST_FETCH_PC;
          end
        end
        `ST_FETCH_PC: begin
          if (VEC_RD_VALID_IN) begin
            VEC_RD_REQ_OUT  <= 1'b0;
            PC_LOAD_OUT     <= 1'b1;
            LOAD_DATA_OUT   <= VEC_RD_DATA_IN;
            CORE_RUN_OUT    <= 1'b1;
            PRIV_THREAD_OUT <= 1'b1; // [RQ5]
            state_reg       <= `ST_RUN;
          end
        end
        `ST_RUN: begin
          if (VTOR_WE_IN)
            vbase_reg <= VTOR_IN & `VEC_BASE_MASK; // [RQ25]
          if (RETURN_IN) begin
            interrupt_status_field_reg        <= RESUME_EXC_IN;
            PRIV_THREAD_OUT <= (RESUME_EXC_IN == 6'h00);
          end else if (take) begin
            ent_num_reg    <= best_num;
            VEC_RD_REQ_OUT <= 1'b1;
            // offset is number times four [RQ13] [RQ14] [RQ15] [RQ16]
            VEC_ADDR_OUT   <= vbase_reg + {24'h00_0000, best_num, 2'b00};
            state_reg      <= `ST_FETCH_VEC;
          end
        end
        `ST_FETCH_VEC: begin
          if (VEC_RD_VALID_IN) begin
            VEC_RD_REQ_OUT <= 1'b0;
            state_reg      <= `ST_RUN;
            // a vector read error leaves the source pending [RQ8]
            if (!VEC_RD_ERR_IN) begin
              PC_LOAD_OUT     <= 1'b1;
              LOAD_DATA_OUT   <= VEC_RD_DATA_IN; // [RQ20]
              ENTRY_OUT       <= 1'b1;
              // pipeline may retire one more instruction first [RQ17]
              ENTRY_ASYNC_OUT <= is_async(ent_num_reg, imprecise_reg);
              interrupt_status_field_reg        <= ent_num_reg;
              PRIV_THREAD_OUT <= 1'b0;
            end
          end
        end
        default: begin
          state_reg      <= `ST_FETCH_SP;
          VEC_RD_REQ_OUT <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // status outputs, one cycle behind the state they mirror
  // ****************************************************************
  always @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      INTERRUPT_STATUS_FIELD_OUT <= 9'h000;
      IRQ_NUMBER_OUT             <= 9'h1F0;
      PENDING_OUT                <= 51'h0;
      ACTIVE_OUT                 <= 51'h0;
    end else begin
      INTERRUPT_STATUS_FIELD_OUT <= {3'b000, interrupt_status_field_reg}; // [RQ22]
      IRQ_NUMBER_OUT             <= {3'b000, interrupt_status_field_reg} - 9'h010; // [RQ22]
      PENDING_OUT                <= pend_reg;
      ACTIVE_OUT                 <= act_reg;
    end
  end

endmodule // exception_unit

// [test/vector_memory.sv]
// vector table memory model on the far side of the vector read bus
// assumes one request at a time, answered with one data word
`timescale 1ns/100ps
module vector_memory (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        req_in,
  input  wire [31:0] addr_in,
  output reg         valid_out,
  output reg  [31:0] data_out
);
  reg [2:0] cnt_reg;
  reg       slow_reg;
  // alternates prompt and slow answers; data toggles when not valid
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'b0;
      data_out  <= 32'h0000_0000;
      cnt_reg   <= 3'h0;
      slow_reg  <= 1'b0;
    end else if (req_in && !valid_out &&
                 cnt_reg == (slow_reg ? 3'h4 : 3'h1)) begin
      valid_out <= 1'b1;
      // handler entries keep bit 0 set
      data_out  <= (addr_in == 32'h0000_0000) ? 32'h2000_1000 :
                   32'h0000_1001 + addr_in;
      cnt_reg   <= 3'h0;
      slow_reg  <= !slow_reg;
    end else begin
      valid_out <= 1'b0;
      data_out  <= ~data_out;
      cnt_reg   <= (req_in && !valid_out) ? cnt_reg + 3'h1 : 3'h0;
    end
  end
endmodule // vector_memory

// [test/exception_unit_sva.sv]
// checker for the exception unit, bound to its top ports
// assumes the vector table is never relocated during the run
`timescale 1ns/100ps
module exception_checker (
  input wire        SYS_CLK_IN,
  input wire        RESET_N_IN,
  input wire        VEC_RD_VALID_IN,
  input wire [31:0] VEC_RD_DATA_IN,
  input wire        VEC_RD_REQ_OUT,
  input wire [31:0] VEC_ADDR_OUT,
  input wire        CORE_RUN_OUT,
  input wire        PRIV_THREAD_OUT,
  input wire        SP_LOAD_OUT,
  input wire        PC_LOAD_OUT,
  input wire [31:0] LOAD_DATA_OUT,
  input wire        ENTRY_OUT,
  input wire        ENTRY_ASYNC_OUT,
  input wire [8:0]  INTERRUPT_STATUS_FIELD_OUT,
  input wire [8:0]  IRQ_NUMBER_OUT,
  input wire [50:0] PENDING_OUT,
  input wire [50:0] ACTIVE_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // address of the last answered read, kept for the entry checks
  reg [31:0] vaddr_reg;
  always @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN) vaddr_reg <= 32'h0000_0000;
    else if (VEC_RD_VALID_IN) vaddr_reg <= VEC_ADDR_OUT;
  chk_sp_fetch: assert property (SP_LOAD_OUT |-> $past(VEC_RD_VALID_IN)
    && $past(VEC_ADDR_OUT) == 32'h0000_0000
    && LOAD_DATA_OUT == $past(VEC_RD_DATA_IN)) else $error("sp fetch");
  chk_boot_run: assert property ($rose(CORE_RUN_OUT) |-> PC_LOAD_OUT
    && PRIV_THREAD_OUT && $past(VEC_ADDR_OUT) == 32'h0000_0004)
    else $error("boot run");
  chk_req_hold: assert property (VEC_RD_REQ_OUT && !VEC_RD_VALID_IN
    |=> VEC_RD_REQ_OUT && $stable(VEC_ADDR_OUT)) else $error("req dropped");
  chk_entry_load: assert property (ENTRY_OUT |-> PC_LOAD_OUT
    && $past(VEC_RD_VALID_IN) && LOAD_DATA_OUT == $past(VEC_RD_DATA_IN))
    else $error("entry load");
  chk_entry_num: assert property (ENTRY_OUT |=>
    INTERRUPT_STATUS_FIELD_OUT == vaddr_reg[10:2]) else $error("entry number");
  chk_entry_active: assert property (ENTRY_OUT |=>
    ACTIVE_OUT[INTERRUPT_STATUS_FIELD_OUT[5:0]]) else $error("not active");
  chk_irq_number: assert property (IRQ_NUMBER_OUT ==
    INTERRUPT_STATUS_FIELD_OUT - 9'h010) else $error("irq number");
  chk_reserved_idle: assert property (((ACTIVE_OUT | PENDING_OUT)
    & 51'h3780) == 51'h0) else $error("reserved used");
  chk_nmi_kept: assert property (INTERRUPT_STATUS_FIELD_OUT == 9'h002
    |-> !ENTRY_OUT) else $error("nmi preempted");
  chk_svc_sync: assert property (ENTRY_OUT && vaddr_reg == 32'h0000_002C
    |-> !ENTRY_ASYNC_OUT) else $error("svc async");
  chk_irq_async: assert property (ENTRY_OUT && vaddr_reg >= 32'h0000_0038
    |-> ENTRY_ASYNC_OUT) else $error("irq sync");
endmodule // exception_checker
bind exception_unit exception_checker chk_u (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
  .VEC_RD_VALID_IN(VEC_RD_VALID_IN), .VEC_RD_DATA_IN(VEC_RD_DATA_IN),
  .VEC_RD_REQ_OUT(VEC_RD_REQ_OUT), .VEC_ADDR_OUT(VEC_ADDR_OUT),
  .CORE_RUN_OUT(CORE_RUN_OUT), .PRIV_THREAD_OUT(PRIV_THREAD_OUT),
  .SP_LOAD_OUT(SP_LOAD_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
  .LOAD_DATA_OUT(LOAD_DATA_OUT), .ENTRY_OUT(ENTRY_OUT),
  .ENTRY_ASYNC_OUT(ENTRY_ASYNC_OUT),
  .INTERRUPT_STATUS_FIELD_OUT(INTERRUPT_STATUS_FIELD_OUT),
  .IRQ_NUMBER_OUT(IRQ_NUMBER_OUT), .PENDING_OUT(PENDING_OUT),
  .ACTIVE_OUT(ACTIVE_OUT));

// [test/exception_unit_bench.sv]
// bench for the exception unit: boot, every source but hard fault, irq pins, nesting
// assumes vector_memory answers reads and the checker is bound in
`timescale 1ns/100ps
module exception_unit_bench;
  reg          clk, rst_n, ok, ret, nmi;
  reg  [34:0]  irq, irq_sw;
  reg  [15:0]  pul;
  reg  [2:0]   cfg;
  reg  [50:0]  ena;
  reg  [203:0] pri;
  reg  [5:0]   rexc;
  wire         vv, vreq, run, priv, ent, easy;
  wire [31:0]  vd, va, ld;
  wire [8:0]   isf, irqn;
  wire [50:0]  pend, act;
  integer      bad_count, n_tests;
  vector_memory mem_u (.clk_in(clk), .rst_n_in(rst_n), .req_in(vreq),
    .addr_in(va), .valid_out(vv), .data_out(vd));
  exception_unit dut_u (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .IRQ_IN(irq),
    .NMI_IN(nmi), .IRQ_SW_SET_IN(irq_sw), .NMI_SW_SET_IN(pul[0]),
    .PENDSRV_SET_IN(pul[1]), .TICK_ZERO_IN(pul[2]), .TICK_SW_SET_IN(pul[3]),
    .SVC_EXEC_IN(pul[4]), .PROT_VIOL_IN(pul[5]), .FIXED_PROT_VIOL_IN(pul[6]),
    .XN_FETCH_IN(pul[7]), .MEMORY_PROTECTION_UNIT_EN_IN(cfg[0]),
    .BUS_ERR_PRECISE_IN(pul[8]), .BUS_ERR_IMPRECISE_IN(pul[9]),
    .UNDEF_INSTR_IN(pul[10]), .ILLEGAL_UNALIGNED_IN(pul[11]),
    .INVALID_STATE_IN(pul[12]), .RETURN_ERR_IN(pul[13]),
    .UNALIGNED_ACCESS_IN(pul[14]), .DIV_ZERO_IN(pul[15]),
    .TRAP_UNALIGNED_EN_IN(cfg[1]), .TRAP_DIV_ZERO_EN_IN(cfg[2]),
    .ENABLE_IN(ena), .PRIORITY_IN(pri), .VTOR_WE_IN(1'b0),
    .VTOR_IN(32'h0000_0000), .ENTRY_OK_IN(ok), .RETURN_IN(ret),
    .RETURN_EXC_IN(rexc), .RESUME_EXC_IN(6'h00), .VEC_RD_VALID_IN(vv),
    .VEC_RD_ERR_IN(1'b0), .VEC_RD_DATA_IN(vd), .VEC_RD_REQ_OUT(vreq),
    .VEC_ADDR_OUT(va), .CORE_RUN_OUT(run), .PRIV_THREAD_OUT(priv),
    .SP_LOAD_OUT(), .PC_LOAD_OUT(), .LOAD_DATA_OUT(ld), .ENTRY_OUT(ent),
    .ENTRY_ASYNC_OUT(easy), .INTERRUPT_STATUS_FIELD_OUT(isf),
    .IRQ_NUMBER_OUT(irqn), .PENDING_OUT(pend), .ACTIVE_OUT(act));
  task bad(input string m);
    begin
      bad_count = bad_count + 1;
      n_tests = n_tests + 1;
      $display("BAD %0t %0s", $time, m);
    end
  endtask
  task good;
    n_tests = n_tests + 1;
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // bounded wait, looked at on falling edges where outputs are settled
  task wait_ent(output bit hit);
    integer k;
    begin
      hit = 1'b0;
      for (k = 0; k < 60 && !hit; k = k + 1) begin
        @(negedge clk);
        hit = (ent === 1'b1);
      end
    end
  endtask
  task expect_ent(input [31:0] off, input bit asy);
    bit h;
    begin
      wait_ent(h);
      if (h !== 1'b1) bad("no entry"); else good;
      if (ld !== 32'h0000_1001 + off) bad("handler"); else good;
      if (easy !== asy) bad("async kind"); else good;
      @(negedge clk);
      if (isf !== off[10:2]) bad("status"); else good;
      if (act[off[7:2]] !== 1'b1) bad("active"); else good;
    end
  endtask
  task ret_to(input [5:0] e);
    begin
      ret = 1'b1;
      rexc = e;
      @(negedge clk);
      ret = 1'b0;
      repeat (3) @(negedge clk);
      if ((act | pend) !== 51'h0) bad("not inactive"); else good;
    end
  endtask
  task boot;
    integer k;
    begin
      rst_n = 1'b0;
      repeat (20) @(negedge clk);
      if (irqn !== 9'h1F0 || run !== 1'b0) bad("in reset"); else good;
      rst_n = 1'b1;
      for (k = 0; k < 40 && run !== 1'b1; k = k + 1) @(negedge clk);
      if (run !== 1'b1 || priv !== 1'b1) bad("boot"); else good;
      if (ld !== 32'h0000_1005) bad("reset pc"); else good;
    end
  endtask
  // rows 16 and 17 are the gated cases: no entry may follow
  task sources;
    integer k;
    reg [31:0] off;
    bit h;
    begin
      for (k = 0; k < 18; k = k + 1) begin
        cfg = (k == 7 || k == 16) ? 3'b110 : (k == 17 ? 3'b011 : 3'b111);
        case (k)
          0: off = 32'h0000_0008;
          1: off = 32'h0000_0038;
          2, 3: off = 32'h0000_003C;
          4: off = 32'h0000_002C;
          5, 6, 7: off = 32'h0000_0010;
          8, 9: off = 32'h0000_0014;
          16, 17: off = 32'h0000_0000;
          default: off = 32'h0000_0018;
        endcase
        @(negedge clk);
        pul[k < 16 ? k : (k == 16 ? 5 : 15)] = 1'b1;
        @(negedge clk);
        pul = 16'h0000;
        if (off == 32'h0000_0000) begin
          wait_ent(h);
          if (h !== 1'b0) bad("gated fault"); else good;
        end else begin
          expect_ent(off, k < 4 || k == 9);
          ret_to(off[7:2]);
        end
      end
    end
  endtask
  task pins;
    integer k;
    begin
      for (k = 0; k < 35; k = k + 34) begin
        ok = 1'b0;
        irq[k] = 1'b1;
        repeat (12) @(negedge clk);
        if (ent !== 1'b0) bad("entry while blocked"); else good;
        ok = 1'b1;
        expect_ent(32'h0000_0040 + 4 * k, 1'b1);
        if (irqn !== k[8:0]) bad("irq number"); else good;
        irq[k] = 1'b0;
        ret_to(16 + k);
      end
    end
  endtask
  task nest;
    bit h;
    begin
      ena[16] = 1'b0;
      pri[68 +: 4] = 4'h1;
      irq_sw = 35'h0000_0000F;
      @(negedge clk);
      irq_sw = 35'h0;
      expect_ent(32'h0000_0048, 1'b1);
      if (pend[19:16] !== 4'hB) bad("held"); else good;
      ena[2] = 1'b0;
      // pin path this time, through the synchroniser
      nmi = 1'b1;
      expect_ent(32'h0000_0008, 1'b1);
      nmi = 1'b0;
      if (act[18] !== 1'b1) bad("nested"); else good;
      irq_sw[2] = 1'b1;
      pul[1] = 1'b1;
      @(negedge clk);
      irq_sw[2] = 1'b0;
      pul[1] = 1'b0;
      wait_ent(h);
      if (h !== 1'b0) bad("nmi preempted"); else good;
      if (pend[18] !== 1'b1) bad("act and pend"); else good;
      ena = {51{1'b1}};
      pri = 204'h0;
      boot;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ok = 1'b1;
    ret = 1'b0;
    nmi = 1'b0;
    irq = 35'h0;
    irq_sw = 35'h0;
    pul = 16'h0000;
    cfg = 3'b111;
    ena = {51{1'b1}};
    pri = 204'h0;
    rexc = 6'h00;
    bad_count = 0;
    n_tests = 0;
    boot;
    sources;
    pins;
    nest;
    summarize;
  end
endmodule // exception_unit_bench
